// *** event_router_pkg.sv ***
// Shared constants for the event channel and consumer router
package event_router_pkg;

   // ****************************************************
   // Sizes
   // ****************************************************
   localparam int NUM_CHANNELS = 6;
   localparam int NUM_USERS = 25;
   localparam int SEL_W = 8;

   // ****************************************************
   // Register indices (byte address = index * 4)
   // ****************************************************
   localparam logic [7:0] STROBE_IDX = 8'h00;
   localparam logic [7:0] CHAN_SEL_IDX = 8'h10;
   localparam logic [7:0] USER_SEL_IDX = 8'h20;
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [7:0] SEL_OFF = 8'h00;

   // ****************************************************
   // Generator values
   // ****************************************************
   localparam logic [7:0] GEN_PIN_LOW = 8'h40;
   localparam logic [7:0] GEN_PIN_HIGH = 8'h48;
   localparam logic [7:0] GEN_TB3_CAPTURE = 8'ha4;
   localparam logic [7:0] GEN_TB3_OVERFLOW = 8'ha5;

   // ****************************************************
   // Consumer numbers
   // ****************************************************
   localparam int USER_LOGIC_TABLE_FIRST = 'h00;
   localparam int USER_LOGIC_TABLE_LAST = 'h07;
   localparam int USER_CONVERTER_START = 'h08;
   localparam int USER_PIN_OUT_FIRST = 'h09;
   localparam int USER_PIN_OUT_LAST = 'h0c;
   localparam int USER_SERIAL_PORT0 = 'h0d;
   localparam int USER_SERIAL_PORT1 = 'h0e;
   localparam int USER_TIMER_A_COUNT = 'h0f;
   localparam int USER_TIMER_A_RESTART = 'h10;
   localparam int USER_TIMER_B_CAPTURE0 = 'h11;
   localparam int USER_TIMER_D_FAULT_A = 'h17;
   localparam int USER_TIMER_D_FAULT_B = 'h18;

   // Consumers that take the registered (synchronous) event
   localparam logic [NUM_USERS-1:0] USER_SYNC_MASK = 25'h055e000;

endpackage : event_router_pkg

// *** user_channel_pick.sv ***
// Picks one channel for one event consumer from its selector value
module user_channel_pick
   import event_router_pkg::*;
#(
   parameter int NCH = NUM_CHANNELS
) (
   // Selector and channels
   input wire logic [SEL_W-1:0] sel_i,
   input wire logic [NCH-1:0] channel_i,
   // Routed event
   output logic event_o
);

   // Zero is off, n selects channel n-1, out of range reads zero
   always_comb begin
      event_o = 1'b0;
      if (sel_i != SEL_OFF && int'(sel_i) <= NCH) begin
         event_o = channel_i[int'(sel_i) - 1];
      end
   end

endmodule // user_channel_pick

// *** event_router.sv ***
// Event channel generator selection and consumer routing with APB registers
//
// What this block does
// - each consumer takes one channel, channels shared
// - selector zero disconnects the consumer
// - selector n routes channel n minus one
// - 8-bit consumer selectors from 0x20, reset zero
// - consumers 0-7 are logic table inputs, async
// - consumers 0x0d, 0x0e serial port inputs, sync
// - consumer 0x0f timer A count input, sync
// - consumer 0x10 timer A restart input, sync
// - timer B capture both ways, count sync
// - generators 0xa4, 0xa5 third timer B events
// - pin event zero when input driver off
// - capture event timing set by the timer
// - one generator per channel, zero is off
// - strobe bit inverts channel one cycle
//
// The implementer's own choice: the APB interface to the registers.
module event_router
   import event_router_pkg::*;
#(
   parameter int NCH = NUM_CHANNELS,
   parameter int NUSR = NUM_USERS
) (
   // Clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Generator events indexed by generator value
   input wire logic [255:0] gen_event_i,
   input wire logic third_timer_b_capture_event_i,
   input wire logic third_timer_b_overflow_event_i,
   // Port pins: levels and input driver enables
   input wire logic [7:0] port_a_level_i,
   input wire logic [7:0] port_a_in_en_i,
   input wire logic [7:0] port_c_level_i,
   input wire logic [7:0] port_c_in_en_i,
   input wire logic [7:0] port_d_level_i,
   input wire logic [7:0] port_d_in_en_i,
   input wire logic [7:0] port_f_level_i,
   input wire logic [7:0] port_f_in_en_i,
   // Routed events
   output logic [NCH-1:0] channel_o,
   output logic [NUSR-1:0] user_event_o
);

   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed {
      logic [NCH-1:0][SEL_W-1:0] chan_sel;
      logic [NUSR-1:0][SEL_W-1:0] user_sel;
      logic [NCH-1:0] strobe;
      logic [NUSR-1:0] user_sync;
      logic [31:0] rdata;
      logic slverr;
   } state_s;

   state_s state_ff;
   state_s nxt_state;

   logic [7:0] pin_a_ev;
   logic [7:0] pin_c_ev;
   logic [7:0] pin_d_ev;
   logic [7:0] pin_f_ev;
   logic [NCH-1:0] chan_raw;
   logic [NCH-1:0] chan_ev;
   logic [NUSR-1:0] user_async;
   logic [7:0] reg_idx;
   logic addr_hi_zero;

   // ****************************************************
   // Functions
   // ****************************************************

   // Register kind: 0 unmapped, 1 strobe, 2 channel select, 3 consumer select
   function automatic logic [1:0] reg_kind(input logic [7:0] idx, input logic ok);
      logic [1:0] k;
      k = 2'h0;
      if (ok) begin
         if (idx == STROBE_IDX) begin
            k = 2'h1;
         end else if (idx >= CHAN_SEL_IDX && idx < CHAN_SEL_IDX + 8'(NCH)) begin
            k = 2'h2;
         end else if (idx >= USER_SEL_IDX && idx < USER_SEL_IDX + 8'(NUSR)) begin
            k = 2'h3;
         end
      end
      return k;
   endfunction

   // Generator value to event for one channel
   function automatic logic gen_pick(input logic [7:0] v, input int ch,
                                     input logic [255:0] gen,
                                     input logic [7:0] pa, input logic [7:0] pc,
                                     input logic [7:0] pd, input logic [7:0] pf,
                                     input logic tb_cap, input logic tb_ovf);
      logic e;
      int pair;
      e = 1'b0;
      pair = ch / 2;
      if (v == SEL_OFF) begin
         e = 1'b0;
      end else if (v == GEN_TB3_CAPTURE) begin
         e = tb_cap;
      end else if (v == GEN_TB3_OVERFLOW) begin
         e = tb_ovf;
      end else if (v >= GEN_PIN_LOW && v < GEN_PIN_HIGH) begin
         // Low pin block: port A on pair 0, port C on pair 1
         if (pair == 0) begin
            e = pa[v[2:0]];
         end else if (pair == 1) begin
            e = pc[v[2:0]];
         end
      end else if (v >= GEN_PIN_HIGH && v < GEN_PIN_HIGH + 8'h08) begin
         // High pin block: port D on pair 1, port F on pair 2
         if (pair == 1) begin
            e = pd[v[2:0]];
         end else if (pair == 2) begin
            e = pf[v[2:0]];
         end
      end else begin
         e = gen[v];
      end
      return e;
   endfunction

   // ****************************************************
   // Pin events
   // ****************************************************

   // Disabled input driver forces the pin event low
   assign pin_a_ev = port_a_level_i & port_a_in_en_i;
   assign pin_c_ev = port_c_level_i & port_c_in_en_i;
   assign pin_d_ev = port_d_level_i & port_d_in_en_i;
   assign pin_f_ev = port_f_level_i & port_f_in_en_i;

   // ****************************************************
   // Channels
   // ****************************************************

   // One generator per channel, inverted by a software strobe
   genvar gc;
   generate
      for (gc = 0; gc < NCH; gc++) begin : g_chan
         assign chan_raw[gc] = gen_pick(state_ff.chan_sel[gc], gc, gen_event_i,
                                        pin_a_ev, pin_c_ev, pin_d_ev, pin_f_ev,
                                        third_timer_b_capture_event_i,
                                        third_timer_b_overflow_event_i);
         assign chan_ev[gc] = chan_raw[gc] ^ state_ff.strobe[gc];
      end
   endgenerate

   assign channel_o = chan_ev;

   // ****************************************************
   // Consumers
   // ****************************************************

   // Each consumer has its own selector; any may share a channel
   genvar gu;
   generate
      for (gu = 0; gu < NUSR; gu++) begin : g_user
         user_channel_pick #(
            .NCH(NCH)
         ) u_pick (
            .sel_i(state_ff.user_sel[gu]),
            .channel_i(chan_ev),
            .event_o(user_async[gu])
         );
      end
   endgenerate

   // Async consumers see the mux directly, sync ones the registered copy
   assign user_event_o = (user_async & ~USER_SYNC_MASK[NUSR-1:0])
                       | (state_ff.user_sync & USER_SYNC_MASK[NUSR-1:0]);

   // ****************************************************
   // APB bus
   // ****************************************************
   assign reg_idx = paddr_i[9:2];
   assign addr_hi_zero = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0);
   assign prdata_o = state_ff.rdata;
   assign pready_o = ce_i;
   assign pslverr_o = state_ff.slverr & psel_i & penable_i;

   // Next-state logic
   always_comb begin
      logic [1:0] kind;
      int sub;
      kind = reg_kind(reg_idx, addr_hi_zero);
      sub = 0;
      nxt_state = state_ff;
      // Strobe lasts a single cycle
      nxt_state.strobe = '0;
      // Sync consumer copies
      nxt_state.user_sync = user_async;
      // Setup phase: latch read data and error
      if (psel_i && !penable_i) begin
         nxt_state.rdata = 32'h0000_0000;
         nxt_state.slverr = (kind == 2'h0);
         if (kind == 2'h2) begin
            sub = int'(reg_idx - CHAN_SEL_IDX);
            nxt_state.rdata = {24'h000000, state_ff.chan_sel[sub]};
         end else if (kind == 2'h3) begin
            sub = int'(reg_idx - USER_SEL_IDX);
            nxt_state.rdata = {24'h000000, state_ff.user_sel[sub]};
         end
      end
      // Access phase write, low byte lane only
      if (psel_i && penable_i && pwrite_i && pstrb_i[0]) begin
         if (kind == 2'h1) begin
            nxt_state.strobe = pwdata_i[NCH-1:0];
         end else if (kind == 2'h2) begin
            sub = int'(reg_idx - CHAN_SEL_IDX);
            nxt_state.chan_sel[sub] = pwdata_i[7:0];
         end else if (kind == 2'h3) begin
            sub = int'(reg_idx - USER_SEL_IDX);
            nxt_state.user_sel[sub] = pwdata_i[7:0];
         end
      end
   end

   // ****************************************************
   // Registers
   // ****************************************************

   // All state, frozen while ce_i is low
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= '0;
      end else if (ce_i) begin
         state_ff <= nxt_state;
      end
   end

endmodule // event_router

// *** event_router_checker.sv ***
// Port checker for the event router
module event_router_checker
   import event_router_pkg::*;
#(parameter int NCH = NUM_CHANNELS, parameter int NUSR = NUM_USERS) (
   // Clock, reset and APB
   input wire logic clk_sys_i, reset_n_i, ce_i, psel_i, penable_i, pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i, prdata_o,
   input wire logic [3:0] pstrb_i,
   input wire logic pready_o, pslverr_o,
   // Routed events
   input wire logic [NCH-1:0] channel_o,
   input wire logic [NUSR-1:0] user_event_o
);
   // Consumers that see the event one clock late
   localparam logic [24:0] SYNC_SET = 25'h055e000;
   logic [7:0] shd_ff [NUSR];
   wire [9:0] idx = paddr_i[11:2];
   wire user_hit = idx >= 10'h20 && idx < 10'h39;
   wire mapped = idx == 10'h0 || (idx >= 10'h10 && idx < 10'h16) || user_hit;
   wire [4:0] uidx = 5'(idx - 10'h20);
   function automatic logic pick(logic [7:0] s, logic [NCH-1:0] c);
      return (s != 8'h00 && s <= NCH) ? c[s-1] : 1'b0;
   endfunction
   // Shadow of the consumer selectors
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < NUSR; i++) shd_ff[i] <= 8'h00;
      end else if (psel_i && penable_i && pwrite_i && pready_o && pstrb_i[0] && user_hit) begin
         shd_ff[uidx] <= pwdata_i[7:0];
      end
   end
   sequence s_setup; psel_i && !penable_i; endsequence
   sequence s_access; psel_i && penable_i && pready_o; endsequence
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   AST_READY: assert property (pready_o == ce_i) else $error("ready not equal enable");
   AST_ERR_PHASE: assert property (pslverr_o |-> psel_i && penable_i) else $error("error outside access");
   AST_UNMAPPED: assert property (s_setup ##1 (s_access and !mapped) |-> pslverr_o)
      else $error("no error on unmapped");
   AST_UPPER_ZERO: assert property (s_setup ##1 (s_access and !pwrite_i) |-> prdata_o[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_READBACK: assert property (s_setup ##1 (s_access and (!pwrite_i && user_hit))
      |-> prdata_o[7:0] == shd_ff[uidx]) else $error("selector readback wrong");
   for (genvar u = 0; u < NUSR; u++) begin : g_u
      if (SYNC_SET[u]) begin : g_s
         AST_SYNC_ROUTE: assert property ($past(ce_i) |-> user_event_o[u] ==
            $past(pick(shd_ff[u], channel_o))) else $error("sync consumer wrong");
      end else begin : g_a
         AST_ASYNC_ROUTE: assert property (user_event_o[u] == pick(shd_ff[u], channel_o))
            else $error("async consumer wrong");
         AST_OFF: assert property (shd_ff[u] == 8'h00 |-> !user_event_o[u])
            else $error("off consumer active");
      end
   end
endmodule // event_router_checker
bind event_router event_router_checker #(.NCH(NCH), .NUSR(NUSR)) i_chk (.clk_sys_i, .reset_n_i,
   .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pstrb_i, .pready_o,
   .pslverr_o, .channel_o, .user_event_o);

// *** event_source_model.sv ***
// Generator side model: random event levels
module event_source_model (
   // Clock, reset, hold
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic hold_i,
   // Generator levels
   output logic [255:0] gen_event_o,
   output logic capture_event_o,
   output logic overflow_event_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int seed = 32'hf94e7067;
   // New levels each cycle unless held; capture and overflow levels are random too
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gen_event_o <= '0;
         capture_event_o <= 1'b0;
         overflow_event_o <= 1'b0;
      end else if (!hold_i) begin
         for (int i = 0; i < 8; i++) gen_event_o[32*i +: 32] <= $random(seed);
         capture_event_o <= 1'($random(seed));
         overflow_event_o <= 1'($random(seed));
      end
   end
endmodule // event_source_model

// *** event_router_bench.sv ***
// Self-checking bench for the event router
module event_router_bench import event_router_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin error_cnt++; \
   $display("[ERR] %s exp=%h got=%h", n, e, g); end end
   logic clk_sys_i = 0, reset_n_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, hold = 0;
   logic [11:0] paddr_i = '0;
   logic [3:0] pstrb_i = 4'hf;
   logic [31:0] pwdata_i = '0, pins = '0, pin_en = '0, prdata_o, rd;
   logic pready_o, pslverr_o, er, cap, ovf;
   logic [255:0] gen;
   logic [NUM_CHANNELS-1:0] channel_o;
   logic [NUM_USERS-1:0] user_event_o;
   logic [7:0] csel [NUM_CHANNELS];
   logic [7:0] usel [NUM_USERS];
   // Pin blocks on own and foreign channel pairs, third timer B events, off
   logic [7:0] corner [2][6] = '{'{8'h00, 8'ha4, 8'ha5, 8'h43, 8'h4a, 8'h4f},
      '{8'h45, 8'h4c, 8'h49, 8'h40, 8'h41, 8'h00}};
   int error_cnt = 0, compares = 0, cyc = 0, seed = 32'hf94e7067;
   event_source_model i_src (.clk_sys_i, .reset_n_i, .hold_i(hold), .gen_event_o(gen),
      .capture_event_o(cap), .overflow_event_o(ovf));
   event_router i_dut (.clk_sys_i, .reset_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .gen_event_i(gen),
      .third_timer_b_capture_event_i(cap), .third_timer_b_overflow_event_i(ovf),
      .port_a_level_i(pins[7:0]), .port_a_in_en_i(pin_en[7:0]), .port_c_level_i(pins[15:8]),
      .port_c_in_en_i(pin_en[15:8]), .port_d_level_i(pins[23:16]),
      .port_d_in_en_i(pin_en[23:16]), .port_f_level_i(pins[31:24]),
      .port_f_in_en_i(pin_en[31:24]), .channel_o, .user_event_o);
   initial forever #12.5 clk_sys_i = ~clk_sys_i;
   // Channel level from its generator value
   function automatic logic chan_exp(int k, logic [7:0] v);
      logic [31:0] p;
      p = pins & pin_en;
      if (v == 8'h00) return 1'b0;
      if (v == 8'ha4) return cap;
      if (v == 8'ha5) return ovf;
      if (v[7:4] != 4'h4) return gen[v];
      if (!v[3] && k < 2) return p[v[2:0]];
      if (!v[3] && k < 4) return p[8+v[2:0]];
      if (v[3] && k >= 2) return p[(k < 4 ? 16 : 24)+v[2:0]];
      return 1'b0;
   endfunction
   function automatic logic user_exp(logic [7:0] s);
      return (s != 0 && s <= NUM_CHANNELS) ? chan_exp(s - 1, csel[s-1]) : 1'b0;
   endfunction
   // One APB transfer; read data and error kept in rd and er
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge clk_sys_i);
      psel_i <= 1; penable_i <= 0; pwrite_i <= wr; paddr_i <= {idx, 2'b00}; pwdata_i <= wd;
      @(posedge clk_sys_i);
      penable_i <= 1;
      do @(posedge clk_sys_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task automatic print_verdict();
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      repeat (16) @(posedge clk_sys_i);
      reset_n_i <= 1;
      for (int u = 0; u < NUM_USERS; u++) begin
         apb(0, 10'h20 + u, 0);
         `CHK("user_sel_reset", 32'h0, rd)
      end
      $display("reset test done");
      // Two corner rounds first, then five random routing rounds
      for (int r = 0; r < 7; r++) begin
         pins <= $random(seed);
         pin_en <= $random(seed);
         for (int k = 0; k < NUM_CHANNELS; k++) begin
            csel[k] = r < 2 ? corner[r][k] : 8'($random(seed));
            apb(1, 10'h10 + k, {24'h0, csel[k]});
            apb(0, 10'h10 + k, 0);
            `CHK("chan_sel", {24'h0, csel[k]}, rd)
         end
         for (int u = 0; u < NUM_USERS; u++) begin
            usel[u] = 8'($random(seed)) & 8'h07;
            apb(1, 10'h20 + u, {24'h0, usel[u]});
            apb(0, 10'h20 + u, 0);
            `CHK("user_sel", {24'h0, usel[u]}, rd)
            `CHK("user_sel_err", 1'b0, er)
         end
         hold <= 1;
         repeat (2) @(posedge clk_sys_i);
         #1;
         for (int k = 0; k < NUM_CHANNELS; k++) `CHK("channel", chan_exp(k, csel[k]), channel_o[k])
         for (int u = 0; u < NUM_USERS; u++) `CHK("user", user_exp(usel[u]), user_event_o[u])
         for (int k = 0; k < NUM_CHANNELS; k++) begin
            apb(1, 10'h00, 32'h1 << k);
            #1;
            `CHK("strobe_pulse", ~chan_exp(k, csel[k]), channel_o[k])
            @(posedge clk_sys_i);
            #1;
            `CHK("strobe_end", chan_exp(k, csel[k]), channel_o[k])
         end
         hold <= 0;
      end
      $display("routing test done");
      apb(1, 10'h05, 32'hff);
      `CHK("unmapped_wr_err", 1'b1, er)
      apb(0, 10'h39, 0);
      `CHK("unmapped_err", 1'b1, er)
      `CHK("unmapped_data", 32'h0, rd)
      // Write with byte lane 0 off leaves the selector alone
      pstrb_i <= 4'h0;
      apb(1, 10'h20, 32'h5);
      pstrb_i <= 4'hf;
      apb(0, 10'h20, 0);
      `CHK("lane_off_write", {24'h0, usel[0]}, rd)
      ce_i <= 0;
      @(posedge clk_sys_i);
      #1;
      `CHK("stall_ready", 1'b0, pready_o)
      ce_i <= 1;
      $display("bus test done");
      print_verdict();
   end
endmodule // event_router_bench
